// file: sfifo_core.sv
// Synchronous FIFO with status flags, reset handling and offset loading
//
// Summary of operation
// - Full flag releases on the read's cycle.
// - Empty flag releases on the write's cycle.
// - Clock may run freely during reset.
// - Pin level at reset picks write2 or load.
// - Data outputs low after reset, enable controls drive.
// - First word appears cycle after empty releases.
// - First word latency bound at empty boundary.
// - Almost-empty flag updates on current read cycle.
// - Almost-empty low when occupancy below offset n.
// - Almost-full low at depth minus (m-1).
// - Almost-full threshold is depth minus offset.
// - Almost-full flag updates on current write cycle.
`timescale 1ns/1ps
`include "sfifo_cfg.svh"

module sfifo_core #(
    parameter int DATA_W = `SFIFO_DATA_W,
    parameter int DEPTH = `SFIFO_DEPTH
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Write side
    input wire logic writeEn_n,
    input wire logic second_write_enable_or_load,
    input wire logic [DATA_W-1:0] dataIn,
    // Read side
    input wire logic readEn_n,
    input wire logic readEn2_n,
    input wire logic outputEnable_n,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOutEn_n,
    // Status flags
    output logic full_flag_n,
    output logic empty_flag_n,
    output logic almost_full_flag_n,
    output logic almost_empty_flag_n
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam int FRL_CYC = `SFIFO_FIRST_WORD_LATENCY_CYC;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    typedef struct packed {
        sfifo_pkg::sfifo_mode_t mode;
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [CW-1:0] count;
        logic [CW-1:0] emptyOffset;
        logic [CW-1:0] fullOffset;
        logic loadWrSel;
        logic loadRdSel;
        logic [DATA_W-1:0] dataOut;
        logic fullN;
        logic emptyN;
        logic almostFullN;
        logic almostEmptyN;
    } sfifo_state_t;

    sfifo_state_t state_q;
    sfifo_state_t state_d;
    logic [DATA_W-1:0] mem [DEPTH];
    logic isLoad;
    logic wrReq;
    logic rdReq;
    logic wrAccept;
    logic rdAccept;
    logic loadWr;
    logic loadRd;
    logic [DATA_W-1:0] rdWord;
    logic [CW-1:0] dataInOff;

    // Request decode; a full or empty FIFO refuses the request
    assign isLoad = (state_q.mode == sfifo_pkg::MODE_LOAD);
    assign wrReq = !writeEn_n && second_write_enable_or_load;
    assign rdReq = !readEn_n && !readEn2_n;
    assign wrAccept = wrReq && state_q.fullN;
    assign rdAccept = rdReq && state_q.emptyN;
    assign loadWr = isLoad && !writeEn_n && !second_write_enable_or_load;
    assign loadRd = isLoad && !readEn_n && !second_write_enable_or_load;
    assign rdWord = mem[state_q.rdPtr];
    assign dataInOff = CW'(dataIn); // Offset-width view of the data bus

    // Storage array write port
    always_ff @(posedge sys_clk) begin
        if (wrAccept) begin
            mem[state_q.wrPtr] <= dataIn;
        end
    end

    // Next-state logic
    always_comb begin
        state_d = state_q;
        if (!rst_n) begin
            // Clocks keep running; all state but the pin-sampled mode holds its reset value
            state_d.wrPtr = '0;
            state_d.rdPtr = '0;
            state_d.count = '0;
            state_d.loadWrSel = 1'b0;
            state_d.loadRdSel = 1'b0;
            state_d.emptyOffset = CW'(`SFIFO_EMPTY_OFFSET_RST);
            state_d.fullOffset = CW'(`SFIFO_FULL_OFFSET_RST);
            state_d.dataOut = `SFIFO_DATA_RST;
            state_d.fullN = 1'b1;
            state_d.emptyN = 1'b0;
            state_d.almostFullN = 1'b1;
            state_d.almostEmptyN = 1'b0;
            // Pin level sampled while reset is held selects its role
            state_d.mode = second_write_enable_or_load ? sfifo_pkg::MODE_WRITE2 : sfifo_pkg::MODE_LOAD;
        end else begin
            if (wrAccept) begin
                state_d.wrPtr = (state_q.wrPtr == AW'(DEPTH - 1)) ? '0 : state_q.wrPtr + AW'(1);
            end
            // Pop presents the word one edge after empty released
            if (rdAccept) begin
                state_d.rdPtr = (state_q.rdPtr == AW'(DEPTH - 1)) ? '0 : state_q.rdPtr + AW'(1);
                state_d.dataOut = rdWord;
            end else if (loadRd) begin
                state_d.dataOut = state_q.loadRdSel ? DATA_W'(state_q.fullOffset) : DATA_W'(state_q.emptyOffset);
                state_d.loadRdSel = !state_q.loadRdSel;
            end
            // Offset loading alternates empty then full offset
            if (loadWr) begin
                if (state_q.loadWrSel) begin
                    state_d.fullOffset = CW'(dataIn);
                end else begin
                    state_d.emptyOffset = CW'(dataIn);
                end
                state_d.loadWrSel = !state_q.loadWrSel;
            end
            case ({wrAccept, rdAccept})
                2'b10: state_d.count = state_q.count + CW'(1);
                2'b01: state_d.count = state_q.count - CW'(1);
                default: state_d.count = state_q.count;
            endcase
            // Single clock: the opposite edge always leads by a full period
            state_d.fullN = (state_d.count != DEPTH_C);
            state_d.emptyN = (state_d.count != '0);
            state_d.almostEmptyN = (state_d.count >= state_d.emptyOffset);
            state_d.almostFullN = (state_d.count <= DEPTH_C - state_d.fullOffset);
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        state_q <= state_d;
    end

    // Outputs from the state register; output enable passes straight through
    assign dataOut = state_q.dataOut;
    assign dataOutEn_n = outputEnable_n;
    assign full_flag_n = state_q.fullN;
    assign empty_flag_n = state_q.emptyN;
    assign almost_full_flag_n = state_q.almostFullN;
    assign almost_empty_flag_n = state_q.almostEmptyN;

    // Checks
    a_full_release: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!full_flag_n && rdAccept) |=> full_flag_n)
        else $error("full flag did not release after read");

    a_empty_release: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!empty_flag_n && wrAccept) |=> empty_flag_n)
        else $error("empty flag did not release after write");

    a_reset_flags: assert property (
        @(posedge sys_clk)
        !rst_n |=> (!empty_flag_n && full_flag_n && !almost_empty_flag_n && almost_full_flag_n))
        else $error("flags wrong after reset cycle");

    a_mode_capture: assert property (
        @(posedge sys_clk)
        (!rst_n && !second_write_enable_or_load) |=> (state_q.mode == sfifo_pkg::MODE_LOAD))
        else $error("load mode not taken at reset");

    a_reset_data: assert property (
        @(posedge sys_clk)
        !rst_n |=> (dataOut == `SFIFO_DATA_RST))
        else $error("data output not low after reset");

    a_first_word: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rdAccept |=> (dataOut == $past(rdWord)))
        else $error("popped word not presented next cycle");

    a_word_latency: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ($rose(empty_flag_n) && rdReq) |-> ##[1:FRL_CYC] (dataOut == $past(rdWord)))
        else $error("first word latency exceeded");

    a_almost_empty: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (rdAccept && !wrAccept && !loadWr && state_q.count == state_q.emptyOffset) |=> !almost_empty_flag_n)
        else $error("almost-empty not asserted at offset");

    a_almost_full: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wrAccept && !rdAccept && !loadWr && state_q.count == DEPTH_C - state_q.fullOffset) |=> !almost_full_flag_n)
        else $error("almost-full not asserted at threshold");

    a_ignore_write: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!full_flag_n && wrReq && !rdReq) |=> ($stable(state_q.wrPtr) && !full_flag_n))
        else $error("write accepted while full");

    a_full_set: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wrAccept && !rdAccept && state_q.count == DEPTH_C - CW'(1)) |=> !full_flag_n)
        else $error("full flag not set on last write");

    a_full_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!full_flag_n && !rdAccept) |=> !full_flag_n)
        else $error("full flag released without read");

    a_full_pointers: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !full_flag_n |-> (state_q.wrPtr == state_q.rdPtr))
        else $error("pointers differ while full");

    a_empty_set: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (rdAccept && !wrAccept && state_q.count == CW'(1)) |=> !empty_flag_n)
        else $error("empty flag not set on last read");

    a_empty_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!empty_flag_n && !wrAccept) |=> !empty_flag_n)
        else $error("empty flag released without write");

    a_empty_pointers: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !empty_flag_n |-> (state_q.wrPtr == state_q.rdPtr))
        else $error("pointers differ while empty");

    a_reset_clear: assert property (
        @(posedge sys_clk)
        !rst_n |=> (state_q.count == '0 && state_q.wrPtr == '0 && state_q.rdPtr == '0))
        else $error("pointers not cleared by reset");

    a_mode_write2: assert property (
        @(posedge sys_clk)
        (!rst_n && second_write_enable_or_load) |=> (state_q.mode == sfifo_pkg::MODE_WRITE2))
        else $error("second enable mode not taken at reset");

    a_mode_hold: assert property (
        @(posedge sys_clk)
        rst_n |=> $stable(state_q.mode))
        else $error("pin role changed outside reset");

    a_load_empty_off: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (loadWr && !state_q.loadWrSel) |=> (state_q.emptyOffset == $past(dataInOff)))
        else $error("empty offset not loaded");

    a_load_full_off: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (loadWr && state_q.loadWrSel) |=> (state_q.fullOffset == $past(dataInOff)))
        else $error("full offset not loaded");

    a_load_no_pop: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (loadRd && !rdAccept) |=> $stable(state_q.rdPtr))
        else $error("offset read moved the read pointer");

    a_data_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!rdAccept && !loadRd) |=> $stable(dataOut))
        else $error("data output changed without read");

    a_almost_empty_rise: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wrAccept && !rdAccept && !loadWr && state_q.count == state_q.emptyOffset - CW'(1)) |=> almost_empty_flag_n)
        else $error("almost-empty not released on write");

    a_almost_empty_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!almost_empty_flag_n && !wrAccept && !loadWr) |=> !almost_empty_flag_n)
        else $error("almost-empty released without write");

    a_almost_full_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!almost_full_flag_n && !rdAccept && !loadWr) |=> !almost_full_flag_n)
        else $error("almost-full released without read");

    a_almost_full_rise: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (rdAccept && !wrAccept && !loadWr && state_q.count == DEPTH_C - state_q.fullOffset + CW'(1))
        |=> almost_full_flag_n)
        else $error("almost-full not released on read");

    a_count_bound: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        state_q.count <= DEPTH_C)
        else $error("occupancy above depth");

    a_ignore_read: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!empty_flag_n && rdReq && !wrReq && !loadRd)
        |=> ($stable(state_q.rdPtr) && $stable(dataOut) && !empty_flag_n))
        else $error("read accepted while empty");

endmodule : sfifo_core

// file: sfifo_cfg.svh
// Constants of the synchronous FIFO flag and reset block
`ifndef SFIFO_CFG_SVH
`define SFIFO_CFG_SVH
`define SFIFO_DATA_W 9
`define SFIFO_DEPTH 64
`define SFIFO_EMPTY_OFFSET_RST 7
`define SFIFO_FULL_OFFSET_RST 7
`define SFIFO_DATA_RST 9'h000
`define SFIFO_CLOCK_PERIOD_NS 25
`define SFIFO_FLAG_SKEW_WINDOW_NS 10
`define SFIFO_PARTIAL_FLAG_SKEW_WINDOW_NS 18
`define SFIFO_FLAG_SKEW_CYC ((`SFIFO_FLAG_SKEW_WINDOW_NS + `SFIFO_CLOCK_PERIOD_NS - 1) / `SFIFO_CLOCK_PERIOD_NS)
`define SFIFO_FIRST_WORD_LATENCY_CYC (1 + `SFIFO_FLAG_SKEW_CYC)
`endif

// file: sfifo_pkg.sv
// Types of the synchronous FIFO flag and reset block
package sfifo_pkg;
    typedef enum logic [1:0] {
        MODE_WRITE2 = 2'b01,
        MODE_LOAD = 2'b10
    } sfifo_mode_t;
endpackage : sfifo_pkg

// file: sfifo_partner.sv
// Writer-side agent that owns the dual-purpose enable pin
`timescale 1ns/1ps
module sfifo_partner (
    // Reset
    input wire logic rst_n,
    // Requests from the bench
    input wire logic loadMode,
    input wire logic pinReq,
    // Dual-purpose pin
    output logic second_write_enable_or_load
);
    // Role level held steady through reset
    always_comb second_write_enable_or_load = rst_n ? pinReq : !loadMode;
endmodule : sfifo_partner

// file: sync_fifo_flag_reset_timing_test.sv
// Testbench of the synchronous FIFO flag and reset block
`timescale 1ns/1ps
module sync_fifo_flag_reset_timing_test;
    // Bench signals
    logic sys_clk = 0, rst_n = 0, writeEn_n = 1, readEn_n = 1, readEn2_n = 1, outputEnable_n = 0;
    logic loadMode = 0, pinReq = 1, wrPin, dataOutEn_n;
    logic [8:0] dataIn = 9'h000, dataOut;
    logic full_flag_n, empty_flag_n, almost_full_flag_n, almost_empty_flag_n;
    int n_errors = 0, checked = 0, cycles = 0, cnt = 0, ae = 7, af = 58;
    // Device and pin agent
    sfifo_core dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .writeEn_n(writeEn_n),
        .second_write_enable_or_load(wrPin), .dataIn(dataIn), .readEn_n(readEn_n), .readEn2_n(readEn2_n),
        .outputEnable_n(outputEnable_n), .dataOut(dataOut), .dataOutEn_n(dataOutEn_n),
        .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
        .almost_empty_flag_n(almost_empty_flag_n));
    sfifo_partner partner_u (.rst_n(rst_n), .loadMode(loadMode), .pinReq(pinReq),
        .second_write_enable_or_load(wrPin));
    // Clock and hang guard
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            test_done();
        end
    end
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One clock of write and/or read, then flag comparison
    task automatic cyc(input logic wr, input logic rd, input logic [8:0] d);
        writeEn_n = !wr;
        readEn_n = !rd;
        readEn2_n = !rd;
        dataIn = d;
        @(negedge sys_clk);
        cnt = cnt + int'(wr && cnt < 64) - int'(rd && cnt > 0);
        chk({5'h00, empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n},
            {5'h00, cnt != 0, cnt != 64, cnt >= ae, cnt < af});
    endtask : cyc
    task automatic do_reset(input logic lm);
        loadMode = lm;
        rst_n = 0;
        repeat (8) @(negedge sys_clk);
        rst_n = 1;
        cnt = 0;
    endtask : do_reset
    // Outputs after reset, and a write blocked by the second enable
    task automatic t_reset();
        chk(dataOut, 9'h000);
        chk({8'h00, dataOutEn_n}, 9'h000);
        outputEnable_n = 1;
        pinReq = 0;
        writeEn_n = 0;
        @(negedge sys_clk);
        chk({8'h00, dataOutEn_n}, 9'h001);
        chk({8'h00, empty_flag_n}, 9'h000);
        outputEnable_n = 0;
        pinReq = 1;
        cyc(0, 0, 9'h000);
    endtask : t_reset
    // First word right after empty releases
    task automatic t_first();
        cyc(1, 0, 9'h1A5);
        cyc(0, 1, 9'h000);
        chk(dataOut, 9'h1A5);
    endtask : t_first
    // Fill past full, then drain past empty
    task automatic t_fill();
        for (int i = 0; i < 66; i++) cyc(1, 0, 9'(i));
        cyc(1, 1, 9'h1FF);
        chk(dataOut, 9'h000);
        for (int i = 1; i < 65; i++) cyc(0, 1, 9'h000);
        chk(dataOut, 9'h03F);
    endtask : t_fill
    // Load mode: program offsets, read both back, check new threshold
    task automatic t_load();
        do_reset(1);
        chk(dataOut, 9'h000);
        readEn_n = 1;
        readEn2_n = 1;
        pinReq = 0;
        writeEn_n = 0;
        dataIn = 9'h002;
        @(negedge sys_clk);
        dataIn = 9'h003;
        @(negedge sys_clk);
        writeEn_n = 1;
        readEn_n = 0;
        @(negedge sys_clk);
        chk(dataOut, 9'h002);
        @(negedge sys_clk);
        chk(dataOut, 9'h003);
        pinReq = 1;
        ae = 2;
        af = 62;
        cyc(1, 0, 9'h005);
        cyc(1, 0, 9'h006);
        for (int i = 0; i < 62; i++) cyc(1, 0, 9'(i));
    endtask : t_load
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    // Main sequence
    initial begin
        do_reset(0);
        t_reset();
        t_first();
        t_fill();
        t_load();
        test_done();
    end
endmodule : sync_fifo_flag_reset_timing_test
